// ### rtl/irt_consts.svh
// constants for the identification register read and trap block
// assumes inclusion by bare name from the decode and top design files
`ifndef IRT_CONSTS_SVH
`define IRT_CONSTS_SVH

// ----------------------------------------------------------------
// encoding tuple fields shared by every register of the bank
// ----------------------------------------------------------------
`define IRT_OP0_SYS 2'h3
`define IRT_OP1_ID 3'h0
`define IRT_CRN_ID 4'h0

// ----------------------------------------------------------------
// per-register encodings
// ----------------------------------------------------------------
`define IRT_CRM_REV 4'h0
`define IRT_OP2_REV 3'h6
`define IRT_CRM_FEAT 4'h1
`define IRT_OP2_PROC0 3'h0
`define IRT_OP2_PROC1 3'h1
`define IRT_OP2_DEBUG0 3'h2
`define IRT_OP2_AUX0 3'h3
`define IRT_OP2_MEM0 3'h4
`define IRT_OP2_MEM1 3'h5

// ----------------------------------------------------------------
// trap syndrome class and reset values
// ----------------------------------------------------------------
`define IRT_EC_SYSREG 6'h18
`define IRT_DATA_RESET 64'h0000_0000_0000_0000
`define IRT_EC_RESET 6'h00

// ----------------------------------------------------------------
// strap synchroniser fill count after reset
// ----------------------------------------------------------------
`define IRT_SYNC_FILL 2'h3

`endif

// ### rtl/irt_pkg.sv
// types for the identification register read and trap block
// the constant values sit in irt_consts.svh, which this package does not include
`default_nettype none

package irt_pkg;

  // ----------------------------------------------------------------
  // exception levels, in natural order 0..3
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {EL_0, EL_1, EL_2, EL_3} irt_el_type;

  // register selected by the decoder
  typedef enum logic [2:0] {
    SEL_NONE, SEL_REV, SEL_PROC0, SEL_PROC1, SEL_DEBUG0, SEL_AUX0, SEL_MEM0, SEL_MEM1
  } irt_sel_type;

  // main block sequencing
  typedef enum logic {ST_CAPTURE, ST_READY} irt_state_type;

  // one system register access from the pipeline
  typedef struct packed {
    logic [1:0] op0;
    logic [2:0] op1;
    logic [3:0] crn;
    logic [3:0] crm;
    logic [2:0] op2;
    logic is_write;
    irt_el_type current_exception_level;
  } irt_req_type;

  // hypervisor and monitor trap controls
  typedef struct packed {
    logic el2_enabled;
    logic hyp_general_trap_bit;
    logic hyp_group1_id_trap_bit;
    logic hyp_group3_id_trap_bit;
    logic monitor_fine_trap_enable;
    logic hyp_fine_read_trap_rev;
  } irt_ctrl_type;

  // answer to the pipeline
  typedef struct packed {
    logic [63:0] data;
    logic hit;
    logic trap;
    logic trap_to_el2;
    logic [5:0] syndrome_class;
    logic undefined;
  } irt_resp_type;

endpackage

`default_nettype wire

// ### rtl/irt_decode.sv
// encoding tuple decoder for the identification register bank
// assumes a request struct from the pipeline, purely combinational
`include "irt_consts.svh"
`default_nettype none

module irt_decode (
  input wire irt_pkg::irt_req_type req,
  output irt_pkg::irt_sel_type sel
);

  // ----------------------------------------------------------------
  // tuple match
  // ----------------------------------------------------------------
  logic common_ok; // op0, op1 and crn shared by all registers

  assign common_ok = (req.op0 == `IRT_OP0_SYS) && (req.op1 == `IRT_OP1_ID)
                     && (req.crn == `IRT_CRN_ID);

  // crm then op2 picks the register; anything else is not ours
  always_comb begin
    sel = irt_pkg::SEL_NONE;
    if (common_ok && req.crm == `IRT_CRM_REV && req.op2 == `IRT_OP2_REV) begin
      sel = irt_pkg::SEL_REV;
    end else if (common_ok && req.crm == `IRT_CRM_FEAT) begin
      unique case (req.op2)
        `IRT_OP2_PROC0: sel = irt_pkg::SEL_PROC0;
        `IRT_OP2_PROC1: sel = irt_pkg::SEL_PROC1;
        `IRT_OP2_DEBUG0: sel = irt_pkg::SEL_DEBUG0;
        `IRT_OP2_AUX0: sel = irt_pkg::SEL_AUX0;
        `IRT_OP2_MEM0: sel = irt_pkg::SEL_MEM0;
        `IRT_OP2_MEM1: sel = irt_pkg::SEL_MEM1;
        default: sel = irt_pkg::SEL_NONE; // op2 6 and 7 lie outside this bank
      endcase
    end
  end

endmodule

`default_nettype wire

// ### rtl/irt_route.sv
// trap routing for a decoded identification register read
// assumes controls come from core logic on the same clock
`default_nettype none

module irt_route (
  input wire irt_pkg::irt_sel_type sel,
  input wire irt_pkg::irt_el_type el,
  input wire irt_pkg::irt_ctrl_type ctrl,
  output logic trap,
  output logic to_el2
);

  // ----------------------------------------------------------------
  // routing decision
  // ----------------------------------------------------------------
  logic is_rev; // revision register has its own level-1 traps

  assign is_rev = (sel == irt_pkg::SEL_REV);

  always_comb begin
    trap = 1'b0;
    to_el2 = 1'b0;
    unique case (el)
      irt_pkg::EL_0: begin
        // user level never reads these directly
        trap = 1'b1;
        to_el2 = ctrl.el2_enabled && ctrl.hyp_general_trap_bit;
      end
      irt_pkg::EL_1: begin
        if (is_rev) begin
          if (ctrl.el2_enabled && ctrl.hyp_group1_id_trap_bit) begin
            trap = 1'b1;
            to_el2 = 1'b1;
          end else if (ctrl.el2_enabled && ctrl.monitor_fine_trap_enable
                       && ctrl.hyp_fine_read_trap_rev) begin
            trap = 1'b1;
            to_el2 = 1'b1;
          end
        end else if (ctrl.el2_enabled && ctrl.hyp_group3_id_trap_bit) begin
          trap = 1'b1;
          to_el2 = 1'b1;
        end
      end
      irt_pkg::EL_2, irt_pkg::EL_3: begin
        trap = 1'b0;
      end
    endcase
  end

endmodule

`default_nettype wire

// ### rtl/irt_top.sv
// identification register bank with read decode and trap routing
// assumes requests arrive from the pipeline on clock; the revision
// value arrives on straps from outside the clock domain
`include "irt_consts.svh"
`default_nettype none

module irt_top #(
  parameter logic [63:0] PROC0_VALUE = `IRT_DATA_RESET,  // reserved content, fixed
  parameter logic [63:0] PROC1_VALUE = `IRT_DATA_RESET,  // reserved content, fixed
  parameter logic [63:0] DEBUG0_VALUE = `IRT_DATA_RESET, // reserved content, fixed
  parameter logic [63:0] AUX0_VALUE = `IRT_DATA_RESET,   // reserved content, fixed
  parameter logic [63:0] MEM0_VALUE = `IRT_DATA_RESET,   // reserved content, fixed
  parameter logic [63:0] MEM1_VALUE = `IRT_DATA_RESET    // reserved content, fixed
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic [63:0] revision_strap,
  input wire logic req_valid,
  input wire irt_pkg::irt_req_type req,
  input wire irt_pkg::irt_ctrl_type ctrl,
  output logic req_ready,
  output logic resp_valid,
  output irt_pkg::irt_resp_type resp
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  // every flip-flop of the block lives in this one struct
  typedef struct packed {
    irt_pkg::irt_state_type state; // capture, then serve reads
    logic [63:0] strap_s1;         // first sync stage, feeds s2 only
    logic [63:0] strap_s2;         // second sync stage
    logic [63:0] strap_s3;         // third sync stage
    logic [1:0] fill;              // edges since reset, saturates at full
    logic [63:0] revision_errata_info; // captured revision value
    logic ready;                   // request acceptance flag
    logic resp_valid;              // one-cycle answer strobe
    irt_pkg::irt_resp_type resp;   // held answer
  } irt_regs_type;

  irt_regs_type r;   // registered state
  irt_regs_type nxt; // next state

  // ----------------------------------------------------------------
  // decode and routing
  // ----------------------------------------------------------------
  irt_pkg::irt_sel_type sel; // register picked by the tuple
  logic route_trap;          // read must trap
  logic route_to_el2;        // trap goes to level 2, else level 1

  // tuple decoder
  irt_decode u_decode (
    .req(req),
    .sel(sel)
  );

  // privilege and hypervisor trap routing
  irt_route u_route (
    .sel(sel),
    .el(req.current_exception_level),
    .ctrl(ctrl),
    .trap(route_trap),
    .to_el2(route_to_el2)
  );

  // ----------------------------------------------------------------
  // read data selection
  // ----------------------------------------------------------------
  // feature contents are reserved; a fixed value stands in for the
  // unknown content so the answer is deterministic in simulation
  function automatic logic [63:0] read_value(input irt_pkg::irt_sel_type s,
                                            input logic [63:0] rev);
    logic [63:0] v;
    v = `IRT_DATA_RESET;
    unique case (s)
      irt_pkg::SEL_REV: v = rev;
      irt_pkg::SEL_PROC0: v = PROC0_VALUE;
      irt_pkg::SEL_PROC1: v = PROC1_VALUE;
      irt_pkg::SEL_DEBUG0: v = DEBUG0_VALUE;
      irt_pkg::SEL_AUX0: v = AUX0_VALUE;
      irt_pkg::SEL_MEM0: v = MEM0_VALUE;
      irt_pkg::SEL_MEM1: v = MEM1_VALUE;
      irt_pkg::SEL_NONE: v = `IRT_DATA_RESET;
    endcase
    return v;
  endfunction

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  // straps are sampled continuously; only the capture state uses them
  always_comb begin
    nxt = r;
    nxt.strap_s1 = revision_strap;
    nxt.strap_s2 = r.strap_s1;
    nxt.strap_s3 = r.strap_s2;
    nxt.resp_valid = 1'b0; // strobe lasts one cycle
    unique case (r.state)
      irt_pkg::ST_CAPTURE: begin
        // the stages still hold reset zeros for three edges, and two
        // zeros agree, so count the fill before trusting agreement
        if (r.fill != `IRT_SYNC_FILL) begin
          nxt.fill = r.fill + 2'h1;
        end else if (r.strap_s2 == r.strap_s3) begin
          // last two stages agree: strap no longer settling
          nxt.revision_errata_info = r.strap_s3;
          nxt.state = irt_pkg::ST_READY;
          nxt.ready = 1'b1;
        end
      end
      irt_pkg::ST_READY: begin
        if (req_valid) begin
          nxt.resp_valid = 1'b1;
          nxt.resp.hit = (sel != irt_pkg::SEL_NONE);
          nxt.resp.data = `IRT_DATA_RESET;
          nxt.resp.trap = 1'b0;
          nxt.resp.trap_to_el2 = 1'b0;
          nxt.resp.syndrome_class = `IRT_EC_RESET;
          nxt.resp.undefined = 1'b0;
          if (sel == irt_pkg::SEL_NONE) begin
            // not our encoding: answer with hit low and no effect
            nxt.resp.hit = 1'b0;
          end else if (req.is_write) begin
            // read-only bank: no store, flagged undefined
            nxt.resp.undefined = 1'b1;
          end else if (route_trap) begin
            nxt.resp.trap = 1'b1;
            nxt.resp.trap_to_el2 = route_to_el2;
            nxt.resp.syndrome_class = `IRT_EC_SYSREG;
          end else begin
            nxt.resp.data = read_value(sel, r.revision_errata_info);
          end
        end
      end
    endcase
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // synchronous reset to constants only; straps are captured later
  always_ff @(posedge clock) begin
    if (srst) begin
      r.state <= irt_pkg::ST_CAPTURE;
      r.strap_s1 <= `IRT_DATA_RESET;
      r.strap_s2 <= `IRT_DATA_RESET;
      r.strap_s3 <= `IRT_DATA_RESET;
      r.fill <= 2'h0;
      r.revision_errata_info <= `IRT_DATA_RESET;
      r.ready <= 1'b0;
      r.resp_valid <= 1'b0;
      r.resp <= '0;
    end else begin
      r <= nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs, straight from flip-flops
  // ----------------------------------------------------------------
  assign req_ready = r.ready;
  assign resp_valid = r.resp_valid;
  assign resp = r.resp;

endmodule

`default_nettype wire

// ### bench/irt_pipe_model.sv
// pipeline model: issues one register access, read or write, at a time, collects the answer
// assumes irt_top registers its answer on the same edge that takes a request
`default_nettype none
module irt_pipe_model (
  input wire logic clock,
  input wire logic req_ready,
  input wire logic resp_valid,
  input wire irt_pkg::irt_resp_type resp,
  output logic req_valid,
  output irt_pkg::irt_req_type req
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    req_valid = 1'b0;
    req = '0;
  end
  // request held until the taking edge; bounded wait for ready
  task automatic issue(input irt_pkg::irt_req_type r, output irt_pkg::irt_resp_type rs,
                       output logic got);
    int n;
    n = 0;
    #1;
    while (req_ready !== 1'b1 && n < 50) begin
      @(posedge clock);
      #1;
      n++;
    end
    @(posedge clock);
    req_valid <= 1'b1;
    req <= r;
    @(posedge clock);
    req_valid <= 1'b0;
    req <= ~r; // released lines must not keep a stale tuple
    #1;
    rs = resp;
    got = resp_valid;
  endtask
endmodule
`default_nettype wire

// ### bench/irt_top_asserts.sv
// timing and answer checks for irt_top
// assumes one clock domain and a synchronous active-high reset
`default_nettype none
module irt_top_asserts (
  input wire logic clock,
  input wire logic srst,
  input wire logic req_valid,
  input wire irt_pkg::irt_req_type req,
  input wire irt_pkg::irt_ctrl_type ctrl,
  input wire logic req_ready,
  input wire logic resp_valid,
  input wire irt_pkg::irt_resp_type resp
);
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  logic bank, rev, trap, el2, hit_r, trap_r, el2_r, wr_r; // expected answer
  assign bank = req.op0 == 2'h3 && req.op1 == 3'h0 && req.crn == 4'h0
    && ((req.crm == 4'h0 && req.op2 == 3'h6) || (req.crm == 4'h1 && req.op2 < 3'h6));
  assign rev = req.crm == 4'h0;
  assign el2 = req.current_exception_level != irt_pkg::EL_0
    || (ctrl.el2_enabled && ctrl.hyp_general_trap_bit);
  assign trap = bank && !req.is_write && (req.current_exception_level == irt_pkg::EL_0
    || (req.current_exception_level == irt_pkg::EL_1 && ctrl.el2_enabled && (rev
    ? ctrl.hyp_group1_id_trap_bit || (ctrl.monitor_fine_trap_enable && ctrl.hyp_fine_read_trap_rev)
    : ctrl.hyp_group3_id_trap_bit)));
  // expectation registered to line up with the answer
  always_ff @(posedge clock) begin
    hit_r <= bank;
    trap_r <= trap;
    el2_r <= el2;
    wr_r <= bank && req.is_write;
  end
  sequence s_take;
    req_valid && req_ready;
  endsequence
  sequence s_answer;
    s_take ##1 resp_valid;
  endsequence
  a_answer_next: assert property (s_take |=> resp_valid)
    else $error("answer missing after request");
  a_no_stray: assert property (!(req_valid && req_ready) |=> !resp_valid)
    else $error("answer without request");
  a_hit_decode: assert property (s_answer |-> resp.hit == hit_r)
    else $error("hit does not match tuple");
  a_trap_when: assert property (s_answer |-> resp.trap == trap_r)
    else $error("trap decision wrong");
  a_trap_level: assert property (s_answer ##0 resp.trap |-> resp.trap_to_el2 == el2_r)
    else $error("trap level wrong");
  a_trap_class: assert property (resp_valid && resp.trap |-> resp.syndrome_class == 6'h18)
    else $error("trap class wrong");
  a_write_undef: assert property (s_answer |-> resp.undefined == wr_r)
    else $error("write not flagged undefined");
  a_resp_holds: assert property (!resp_valid |-> $stable(resp))
    else $error("answer changed between strobes");
endmodule
bind irt_top irt_top_asserts u_asserts (.clock(clock), .srst(srst), .req_valid(req_valid),
  .req(req), .ctrl(ctrl), .req_ready(req_ready), .resp_valid(resp_valid), .resp(resp));
`default_nettype wire

// ### bench/id_sysreg_read_trap_test.sv
// self-checking bench for the id register read and trap block
// assumes the pipeline model and checker are compiled before it
`default_nettype none
module id_sysreg_read_trap_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [63:0] REV_A = 64'h0123_4567_89AB_CDEF; // arbitrary strap pattern
  localparam logic [63:0] REV_B = 64'hFEDC_BA98_7654_3210;
  logic clock, srst, req_valid, req_ready, resp_valid, got, bank, trap;
  logic [63:0] strap;
  irt_pkg::irt_req_type req, r;
  irt_pkg::irt_ctrl_type ctrl;
  irt_pkg::irt_resp_type resp, rs;
  int errors, checked;
  irt_top #(.PROC0_VALUE(64'hF0), .PROC1_VALUE(64'hF1), .DEBUG0_VALUE(64'hF2),
    .AUX0_VALUE(64'hF3), .MEM0_VALUE(64'hF4)) dut (.clock(clock),
    .srst(srst), .revision_strap(strap), .req_valid(req_valid), .req(req), .ctrl(ctrl),
    .req_ready(req_ready), .resp_valid(resp_valid), .resp(resp));
  irt_pipe_model pipe (.clock(clock), .req_ready(req_ready), .resp_valid(resp_valid),
    .resp(resp), .req_valid(req_valid), .req(req));
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] seen);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic report_and_stop;
    if (errors == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic do_reset;
    @(posedge clock);
    srst <= 1'b1;
    repeat (4) @(posedge clock);
    srst <= 1'b0;
  endtask
  task automatic rev_read(input logic [63:0] exp);
    r = '0;
    r.op0 = 2'h3;
    r.op2 = 3'h6;
    r.current_exception_level = irt_pkg::EL_3;
    pipe.issue(r, rs, got);
    chk("revision", exp, rs.data);
  endtask
  // watchdog: the sweep needs about 13800 cycles
  initial begin
    repeat (40000) @(posedge clock);
    errors++;
    report_and_stop();
  end
  // every bank tuple and two outside it, every level, control pattern, read and write
  initial begin
    errors = 0;
    checked = 0;
    srst = 1'b1;
    strap = REV_A;
    ctrl = '0;
    do_reset();
    for (int w = 0; w < 2; w++)
      for (int e = 0; e < 9; e++)
        for (int l = 0; l < 4; l++)
          for (int c = 0; c < 64; c++) begin
            @(posedge clock);
            ctrl <= c[5:0];
            r = '0;
            r.op0 = (e == 8) ? 2'h2 : 2'h3;
            r.crm = (e == 6 || e == 8) ? 4'h0 : 4'h1;
            r.op2 = (e < 6) ? 3'(e) : 3'h6;
            r.is_write = w[0];
            r.current_exception_level = irt_pkg::irt_el_type'(l);
            bank = e < 7;
            trap = bank && !w && (l == 0 || (l == 1 && c[5]
              && ((e == 6) ? c[3] || (c[1] && c[0]) : c[2])));
            pipe.issue(r, rs, got);
            chk("strobe", 1, got);
            chk("hit", bank, rs.hit);
            chk("trap", trap, rs.trap);
            chk("undefined", bank && w, rs.undefined);
            if (trap) begin
              chk("route", l != 0 || (c[5] && c[4]), rs.trap_to_el2);
              chk("class", 64'h18, rs.syndrome_class);
            end else if (!w) begin
              chk("data", (!bank || e == 5) ? 64'h0 : (e == 6) ? REV_A : 64'hF0 + e,
                  rs.data);
            end
          end
    @(posedge clock);
    strap <= REV_B;
    repeat (6) @(posedge clock);
    rev_read(REV_A);
    do_reset();
    rev_read(REV_B);
    report_and_stop();
  end
endmodule
`default_nettype wire
